// ### common/asc_defs.svh
// Offsets, field positions, reset values and masks of the system control bank
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ASC_ADDR_ERR 8'h02
`define ASC_ADDR_SC1 8'h03
`define ASC_ADDR_FMT 8'h04
`define ASC_ADDR_SC2 8'h05

// ****************************************
// Reset values
// ****************************************
`define ASC_RST_ERR 8'h00
`define ASC_RST_SC1 8'ha0
`define ASC_RST_FMT 8'h05
`define ASC_RST_SC2 8'h40

// ****************************************
// Writable bits; all others read as default
// ****************************************
`define ASC_WMASK_SC1 8'haf
`define ASC_WMASK_FMT 8'h1f
`define ASC_WMASK_SC2 8'h6e

// ****************************************
// Field positions
// ****************************************
`define ASC_ERR_LSB 3
`define ASC_ERR_MSB 6
`define ASC_SC1_DCBLK 7
`define ASC_SC1_HARDUNM 5
`define ASC_SC1_ADET_DIS 3
`define ASC_SC1_SSTART_DIS 2
`define ASC_SC1_DEEMPH_MSB 1
`define ASC_SC2_SHUTDOWN 6
`define ASC_SC2_ALLCH 5
`define ASC_SC2_VOLSRC 3
`define ASC_SC2_MODE_MSB 2
`define ASC_SC2_MODE_LSB 1
`define ASC_FMT_MSB 4

`endif

// ### common/asc_pkg.sv
// Types shared by the system control bank and its helpers
package asc_pkg;

	// Fault events in error register order, D6 down to D3
	typedef struct packed {
		logic pll_autolock;
		logic bit_clock;
		logic frame_clock;
		logic frame_slip;
	} asc_err_t;

	typedef enum logic [1:0] {
		ASC_DEEMPH_NONE,
		ASC_DEEMPH_RSVD,
		ASC_DEEMPH_44K1,
		ASC_DEEMPH_48K
	} asc_deemph_t;

	typedef struct packed {
		logic dc_block_en;
		logic hard_unmute;
		logic autodetect_en;
		logic soft_start_en;
		asc_deemph_t deemph;
	} asc_ctl_t;

	typedef enum logic [1:0] {
		ASC_FMT_RJ,
		ASC_FMT_I2S,
		ASC_FMT_LJ,
		ASC_FMT_RSVD
	} asc_fmt_t;

	typedef struct packed {
		asc_fmt_t kind;
		logic [4:0] word_len;
		logic sclk_32fs;
	} asc_fmt_info_t;

	typedef struct packed {
		logic speaker;
		logic headphone;
		logic line_out;
		logic hp_vol_reg;
		logic hp_active;
		logic others_active;
	} asc_mode_t;

endpackage : asc_pkg

// ### design/asc_err_flags.sv
// Sticky error flags: set by fault events, cleared only by software writes or by reset
`timescale 1ns/1ps
module asc_err_flags #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Fault events
	input wire logic [WIDTH-1:0] set_evt,
	// Software write
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	// Flags
	output logic [WIDTH-1:0] flags
);
	logic [WIDTH-1:0] flag_r;
	logic [WIDTH-1:0] flag_nxt;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			// Event wins over a clearing write in the same cycle
			always_comb begin
				if (wr_en) begin
					flag_nxt[i] = wr_data[i] | set_evt[i]; // R01 R21
				end else begin
					flag_nxt[i] = flag_r[i] | set_evt[i]; // R01 R21
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_r <= '0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign flags = flag_r;
endmodule : asc_err_flags

// ### design/asc_mode_dec.sv
// Output mode decode from mode bits, volume source bit and headphone pin
`timescale 1ns/1ps
module asc_mode_dec (
	// Control bits
	input wire logic [1:0] mode_bits,
	input wire logic vol_src,
	// Pin
	input wire logic headphone_select_pin,
	// Decoded mode
	output asc_pkg::asc_mode_t mode
);
	import asc_pkg::*;

	always_comb begin
		mode = '0;
		case (mode_bits)
			2'h0: begin
				mode.headphone = headphone_select_pin; // R16
			end
			2'h1: begin
				mode.headphone = 1'b1; // R16
			end
			2'h2: begin
				mode.line_out = 1'b1; // R18
			end
			default: begin
				// Reserved code behaves as mode 00: speaker unless the pin is high
				mode.headphone = headphone_select_pin;
			end
		endcase
		mode.speaker = !mode.headphone && !mode.line_out;
		// Headphone register only while in headphone mode with D3 low
		mode.hp_vol_reg = mode.headphone && !vol_src; // R15
		mode.hp_active = mode.headphone || mode.line_out; // R18
		// Headphone mode mutes every non-headphone channel
		mode.others_active = !mode.headphone; // R17 R18
	end
endmodule : asc_mode_dec

// ### design/asc_sysctl.sv
// System control and status register bank of the audio processor
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "asc_defs.svh"

//Function
// R01: Error flags are sticky; only software writes clear them.
// R02: Error bits D6..D3: PLL lock, bit clock, frame clock, slip; reset 0.
// R03: Control one D7 enables dc-blocking filter; default enabled.
// R04: Control one D5: 0 soft unmute, 1 hard unmute; default 1.
// R05: Control one D3 low enables clock autodetect; default low.
// R06: Control one D2 low enables soft start; default low.
// R07: Control one D1..D0 select de-emphasis: none, reserved, 44.1k, 48k.
// R08: Serial format resets to I2S 24-bit, code 00101.
// R09: Low five bits pick format; upper three read zero.
// R10: Codes 10011 and 10110 use 32 fs bit clock; others reserved.
// R11: Control two D6 low plays; high shuts all outputs in hard mute.
// R12: D5 high starts all channels; low starts those outside shutdown group.
// R13: Host changes D5 only while D6 is set.
// R14: Output valid is 0 while shut down, 1 when all channels run.
// R15: D3 picks headphone volume from headphone register or channel registers.
// R16: Mode 00 speaker unless pin high; 01 headphone ORed with pin.
// R17: Forced headphone mode mutes all non-headphone channels.
// R18: Mode 10 line-out ignores pin; headphone and other channels active.
// R19: Host sets D3 whenever line-out mode is selected.
// R20: Host confirms manual clock settings by writing clock-valid bit.
// R21: Hardware sets an error flag on each detected fault.
// R22: Reserved bits read their default and writes to them do nothing.
module asc_sysctl #(
	parameter int NUM_CH = 6,
	parameter logic [NUM_CH-1:0] HP_CH_MASK = 6'h10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Fault events, one cycle pulses
	input wire asc_pkg::asc_err_t fault_evt,
	// Pins and neighbouring registers
	input wire logic headphone_select_pin,
	input wire logic [NUM_CH-1:0] shutdown_group,
	// Error flags
	output asc_pkg::asc_err_t err_flags,
	// Processing controls
	output asc_pkg::asc_ctl_t ctl,
	output asc_pkg::asc_fmt_info_t fmt_info,
	output logic fmt_reserved,
	// Run and mode state
	output logic play,
	output logic all_channels_cfg,
	output logic [NUM_CH-1:0] ch_run,
	output logic output_valid,
	output asc_pkg::asc_mode_t out_mode
);
	import asc_pkg::*;

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] sc1_r;
	logic [7:0] sc1_nxt;
	logic [7:0] fmt_r;
	logic [7:0] fmt_nxt;
	logic [7:0] sc2_r;
	logic [7:0] sc2_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	logic wr_err;
	logic wr_sc1;
	logic wr_fmt;
	logic wr_sc2;
	asc_err_t err_q;

	assign wr_err = reg_wr && (reg_addr == `ASC_ADDR_ERR);
	assign wr_sc1 = reg_wr && (reg_addr == `ASC_ADDR_SC1);
	assign wr_fmt = reg_wr && (reg_addr == `ASC_ADDR_FMT);
	assign wr_sc2 = reg_wr && (reg_addr == `ASC_ADDR_SC2);

	// ****************************************
	// Sticky error flags
	// ****************************************
	asc_err_flags #(
		.WIDTH($bits(asc_err_t))
	) u_err (
		.clk(clk),
		.resetn(resetn),
		.set_evt(fault_evt), // R21
		.wr_en(wr_err), // R01
		.wr_data(reg_wdata[`ASC_ERR_MSB:`ASC_ERR_LSB]),
		.flags(err_q) // R02
	);

	// ****************************************
	// Control register writes
	// ****************************************
	// Reserved bits keep their default whatever is written
	always_comb begin
		sc1_nxt = sc1_r;
		fmt_nxt = fmt_r;
		sc2_nxt = sc2_r;
		if (wr_sc1) begin
			sc1_nxt = (reg_wdata & `ASC_WMASK_SC1) |
				(`ASC_RST_SC1 & ~`ASC_WMASK_SC1); // R22
		end
		if (wr_fmt) begin
			fmt_nxt = reg_wdata & `ASC_WMASK_FMT; // R09
		end
		if (wr_sc2) begin
			sc2_nxt = (reg_wdata & `ASC_WMASK_SC2) |
				(`ASC_RST_SC2 & ~`ASC_WMASK_SC2); // R22
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sc1_r <= `ASC_RST_SC1; // R03 R04 R05 R06 R07
			fmt_r <= `ASC_RST_FMT; // R08
			sc2_r <= `ASC_RST_SC2; // R11
		end else begin
			sc1_r <= sc1_nxt;
			fmt_r <= fmt_nxt;
			sc2_r <= sc2_nxt;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Data stand only in the cycle after the strobe
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`ASC_ADDR_ERR: begin
					rdata_nxt[`ASC_ERR_MSB:`ASC_ERR_LSB] = err_q; // R02
				end
				`ASC_ADDR_SC1: begin
					rdata_nxt = sc1_r;
				end
				`ASC_ADDR_FMT: begin
					rdata_nxt = fmt_r; // R09
				end
				`ASC_ADDR_SC2: begin
					rdata_nxt = sc2_r;
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ****************************************
	// Serial format decode
	// ****************************************
	function automatic asc_fmt_info_t fmt_decode(input logic [4:0] code);
		asc_fmt_info_t f;
		f.kind = ASC_FMT_RSVD;
		f.word_len = 5'd0;
		f.sclk_32fs = 1'b0;
		case (code)
			5'h00: begin
				f.kind = ASC_FMT_RJ;
				f.word_len = 5'd16;
			end
			5'h01: begin
				f.kind = ASC_FMT_RJ;
				f.word_len = 5'd20;
			end
			5'h02: begin
				f.kind = ASC_FMT_RJ;
				f.word_len = 5'd24;
			end
			5'h03: begin
				f.kind = ASC_FMT_I2S;
				f.word_len = 5'd16;
			end
			5'h04: begin
				f.kind = ASC_FMT_I2S;
				f.word_len = 5'd20;
			end
			5'h05: begin
				f.kind = ASC_FMT_I2S;
				f.word_len = 5'd24;
			end
			5'h06: begin
				f.kind = ASC_FMT_LJ;
				f.word_len = 5'd16;
			end
			5'h07: begin
				f.kind = ASC_FMT_LJ;
				f.word_len = 5'd20;
			end
			5'h08: begin
				f.kind = ASC_FMT_LJ;
				f.word_len = 5'd24;
			end
			5'h0a: begin
				f.kind = ASC_FMT_RJ;
				f.word_len = 5'd18;
			end
			5'h13: begin
				f.kind = ASC_FMT_I2S; // R10
				f.word_len = 5'd16;
				f.sclk_32fs = 1'b1;
			end
			5'h16: begin
				f.kind = ASC_FMT_LJ; // R10
				f.word_len = 5'd16;
				f.sclk_32fs = 1'b1;
			end
			default: begin
				f.kind = ASC_FMT_RSVD; // R10
			end
		endcase
		return f;
	endfunction : fmt_decode

	// ****************************************
	// Output mode and channel run decode
	// ****************************************
	asc_mode_t mode_c;

	asc_mode_dec u_mode (
		.mode_bits(sc2_r[`ASC_SC2_MODE_MSB:`ASC_SC2_MODE_LSB]),
		.vol_src(sc2_r[`ASC_SC2_VOLSRC]),
		.headphone_select_pin(headphone_select_pin),
		.mode(mode_c)
	);

	asc_ctl_t ctl_c;
	asc_fmt_info_t fmt_c;
	logic fmt_rsvd_c;
	logic play_c;
	logic [NUM_CH-1:0] run_c;
	logic valid_c;

	always_comb begin
		ctl_c.dc_block_en = sc1_r[`ASC_SC1_DCBLK]; // R03
		ctl_c.hard_unmute = sc1_r[`ASC_SC1_HARDUNM]; // R04
		ctl_c.autodetect_en = !sc1_r[`ASC_SC1_ADET_DIS]; // R05
		ctl_c.soft_start_en = !sc1_r[`ASC_SC1_SSTART_DIS]; // R06
		ctl_c.deemph = asc_deemph_t'(sc1_r[`ASC_SC1_DEEMPH_MSB:0]); // R07
		fmt_c = fmt_decode(fmt_r[`ASC_FMT_MSB:0]); // R09
		fmt_rsvd_c = (fmt_c.kind == ASC_FMT_RSVD);
		play_c = !sc2_r[`ASC_SC2_SHUTDOWN]; // R11
	end

	// Per channel: playing, in configuration, and not muted by mode
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_run
			always_comb begin
				if (!play_c) begin
					run_c[ch] = 1'b0; // R11
				end else if (HP_CH_MASK[ch]) begin
					run_c[ch] = mode_c.hp_active &&
						(sc2_r[`ASC_SC2_ALLCH] ||
						!shutdown_group[ch]); // R12 R18
				end else begin
					run_c[ch] = mode_c.others_active &&
						(sc2_r[`ASC_SC2_ALLCH] ||
						!shutdown_group[ch]); // R12 R17
				end
			end
		end
	endgenerate

	// Valid once every channel is started with nothing held back
	always_comb begin
		valid_c = play_c && (sc2_r[`ASC_SC2_ALLCH] ||
			(shutdown_group == '0)); // R14
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	asc_ctl_t ctl_r;
	asc_fmt_info_t fmt_info_r;
	logic fmt_rsvd_r;
	logic play_r;
	logic allch_r;
	logic [NUM_CH-1:0] run_r;
	logic valid_r;
	asc_mode_t mode_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl_r <= '{dc_block_en: 1'b1, hard_unmute: 1'b1,
				autodetect_en: 1'b1, soft_start_en: 1'b1,
				deemph: ASC_DEEMPH_NONE};
			fmt_info_r <= '{kind: ASC_FMT_I2S, word_len: 5'd24,
				sclk_32fs: 1'b0};
			fmt_rsvd_r <= 1'b0;
			play_r <= 1'b0;
			allch_r <= 1'b0;
			run_r <= '0;
			valid_r <= 1'b0; // R14
			mode_r <= '0;
		end else begin
			ctl_r <= ctl_c;
			fmt_info_r <= fmt_c;
			fmt_rsvd_r <= fmt_rsvd_c;
			play_r <= play_c;
			allch_r <= sc2_r[`ASC_SC2_ALLCH]; // R13
			run_r <= run_c;
			valid_r <= valid_c;
			mode_r <= mode_c;
		end
	end

	assign reg_rdata = rdata_r;
	assign err_flags = err_q;
	assign ctl = ctl_r;
	assign fmt_info = fmt_info_r;
	assign fmt_reserved = fmt_rsvd_r;
	assign play = play_r;
	assign all_channels_cfg = allch_r;
	assign ch_run = run_r;
	assign output_valid = valid_r;
	assign out_mode = mode_r;
endmodule : asc_sysctl

// ### bench/asc_sysctl_assertions.sv
// Port checker of the system control bank
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_sysctl_assertions #(
	parameter int NUM_CH = 6,
	parameter logic [NUM_CH-1:0] HP_CH_MASK = 6'h10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Events and pins
	input wire asc_pkg::asc_err_t fault_evt,
	input wire logic headphone_select_pin,
	input wire logic [NUM_CH-1:0] shutdown_group,
	// Outputs
	input wire asc_pkg::asc_err_t err_flags,
	input wire asc_pkg::asc_ctl_t ctl,
	input wire asc_pkg::asc_fmt_info_t fmt_info,
	input wire logic fmt_reserved,
	input wire logic play,
	input wire logic all_channels_cfg,
	input wire logic [NUM_CH-1:0] ch_run,
	input wire logic output_valid,
	input wire asc_pkg::asc_mode_t out_mode
);
	import asc_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic err_wr;
	assign err_wr = reg_wr && reg_addr == `ASC_ADDR_ERR;
	err_hold_a: assert property (
		resetn && !err_wr |=>
		err_flags == ($past(err_flags) | $past(fault_evt)))
		else $error("error flag changed without cause");
	err_write_a: assert property (
		err_wr |=> err_flags == ($past(reg_wdata[6:3]) | $past(fault_evt)))
		else $error("error write mismatch");
	err_read_a: assert property (
		reg_rd && reg_addr == `ASC_ADDR_ERR |=>
		reg_rdata == {1'b0, $past(err_flags), 3'b000})
		else $error("error read mismatch");
	rd_quiet_a: assert property (
		!(reg_rd && reg_addr inside {[8'h02:8'h05]}) |=> reg_rdata == 8'h00)
		else $error("read data outside a read");
	play_ctl_a: assert property (
		reg_wr && reg_addr == `ASC_ADDR_SC2 |-> ##2
		play == !$past(reg_wdata[6], 2))
		else $error("play does not follow shutdown bit");
	sc1_decode_a: assert property (
		reg_wr && reg_addr == `ASC_ADDR_SC1 |-> ##2
		ctl.dc_block_en == $past(reg_wdata[7], 2) &&
		ctl.autodetect_en != $past(reg_wdata[3], 2))
		else $error("control one decode mismatch");
	out_valid_a: assert property (
		output_valid == (play &&
		(all_channels_cfg || $past(shutdown_group) == '0)))
		else $error("output valid mismatch");
	chan_run_a: assert property (
		ch_run == ({NUM_CH{play}} &
		({NUM_CH{all_channels_cfg}} | ~$past(shutdown_group)) &
		(HP_CH_MASK & {NUM_CH{out_mode.hp_active}} |
		~HP_CH_MASK & {NUM_CH{out_mode.others_active}})))
		else $error("channel run mismatch");
	pin_hp_a: assert property (
		resetn && headphone_select_pin ##1 !out_mode.line_out |->
		out_mode.headphone)
		else $error("pin did not force headphone mode");
	line_out_a: assert property (
		out_mode.line_out |-> out_mode.hp_active &&
		out_mode.others_active && !out_mode.headphone)
		else $error("line out mode mismatch");
	forced_hp_a: assert property (
		out_mode.headphone |-> !out_mode.others_active && !out_mode.speaker)
		else $error("headphone mode left channels on");
	cover property (output_valid);
	cover property (err_wr && fault_evt != 4'h0);
	cover property (out_mode.line_out);
endmodule : asc_sysctl_assertions

bind asc_sysctl asc_sysctl_assertions #(.NUM_CH(NUM_CH),
	.HP_CH_MASK(HP_CH_MASK)) u_chk (.clk(clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_evt(fault_evt),
	.headphone_select_pin(headphone_select_pin),
	.shutdown_group(shutdown_group), .err_flags(err_flags), .ctl(ctl),
	.fmt_info(fmt_info), .fmt_reserved(fmt_reserved), .play(play),
	.all_channels_cfg(all_channels_cfg), .ch_run(ch_run),
	.output_valid(output_valid), .out_mode(out_mode));

// ### bench/asc_host.sv
// Host model that programs the system control bank
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_host (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	logic [7:0] shadow = 8'h40;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Strobe stays high so that writes follow with no gap
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= ~reg_wdata;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
		@(posedge clk);
	endtask : rd
	// Configuration bit moves only while shut down
	task automatic sc2(input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (d[2:1] == 2'b10)
			v[3] = 1'b1;
		wr(`ASC_ADDR_SC2, shadow | 8'h40);
		wr(`ASC_ADDR_SC2, v | 8'h40);
		wr(`ASC_ADDR_SC2, v);
		shadow = v;
	endtask : sc2
endmodule : asc_host

// ### bench/asc_sysctl_tb.sv
// Self-checking bench of the system control bank
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_sysctl_tb;
	import asc_pkg::*;
	typedef struct packed {
		logic [7:0] a, d, r;
		logic [8:0] x, m;
	} asc_row_t;
	logic clk, resetn, reg_wr, reg_rd, headphone_select_pin;
	logic fmt_reserved, play, all_channels_cfg, output_valid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
	logic [8:0] s;
	logic [5:0] shutdown_group, ch_run;
	asc_err_t fault_evt, err_flags;
	asc_ctl_t ctl;
	asc_fmt_info_t fmt_info;
	asc_mode_t out_mode;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	// Address, data, readback, decode and decode mask
	asc_row_t rows [21] = '{
		'{8'h03,8'hff,8'haf,9'h033,9'h03f}, '{8'h03,8'h00,8'h00,9'h00c,9'h03f},
		'{8'h03,8'h01,8'h01,9'h00d,9'h03f}, '{8'h03,8'h28,8'h28,9'h014,9'h03f},
		'{8'h03,8'ha2,8'ha2,9'h03e,9'h03f}, '{8'h04,8'h00,8'h00,9'h020,9'h1ff},
		'{8'h04,8'h01,8'h01,9'h028,9'h1ff}, '{8'h04,8'h02,8'h02,9'h030,9'h1ff},
		'{8'h04,8'h03,8'h03,9'h060,9'h1ff}, '{8'h04,8'h04,8'h04,9'h068,9'h1ff},
		'{8'h04,8'he5,8'h05,9'h070,9'h1ff}, '{8'h04,8'h06,8'h06,9'h0a0,9'h1ff},
		'{8'h04,8'h07,8'h07,9'h0a8,9'h1ff}, '{8'h04,8'h08,8'h08,9'h0b0,9'h1ff},
		'{8'h04,8'h0a,8'h0a,9'h024,9'h1ff}, '{8'h04,8'h13,8'h13,9'h061,9'h1ff},
		'{8'h04,8'h16,8'h16,9'h081,9'h1c1}, '{8'h04,8'h09,8'h09,9'h100,9'h100},
		'{8'h04,8'h1f,8'h1f,9'h100,9'h100}, '{8'h06,8'hff,8'h00,9'h1c0,9'h1ff},
		'{8'h00,8'hff,8'h00,9'h1c0,9'h1ff}
	};
	asc_sysctl dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .fault_evt(fault_evt),
		.headphone_select_pin(headphone_select_pin),
		.shutdown_group(shutdown_group), .err_flags(err_flags), .ctl(ctl),
		.fmt_info(fmt_info), .fmt_reserved(fmt_reserved), .play(play),
		.all_channels_cfg(all_channels_cfg), .ch_run(ch_run),
		.output_valid(output_valid), .out_mode(out_mode));
	asc_host h (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	task automatic reset_chk();
		logic [7:0] e [4];
		e = '{8'h00, 8'ha0, 8'h05, 8'h40};
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk("reset state", 9'h000, {7'h00, play, output_valid});
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			h.rd(8'h02 + 8'(i), v);
			chk("reset value", {1'b0, e[i]}, {1'b0, v});
		end
	endtask : reset_chk
	task automatic run_case(input logic [7:0] d, input logic p,
		input logic [5:0] om, input logic [5:0] cr, input logic ov);
		headphone_select_pin <= p;
		h.sc2(d);
		h.rd(`ASC_ADDR_SC2, v);
		chk("control two", {1'b0, d & 8'h6e}, {1'b0, v});
		chk("mode", {3'h0, om}, {3'h0, out_mode});
		chk("run", {3'h0, cr}, {3'h0, ch_run});
		chk("play", {7'h00, !d[6], ov}, {7'h00, play, output_valid});
		chk("config", {8'h00, d[5]}, {8'h00, all_channels_cfg});
	endtask : run_case
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		resetn = 1'b0;
		fault_evt = 4'h0;
		headphone_select_pin = 1'b0;
		shutdown_group = 6'h00;
		reset_chk();
		foreach (rows[i]) begin
			h.wr(rows[i].a, rows[i].d);
			// Manual clock settings are confirmed by the host
			if (rows[i].a == `ASC_ADDR_SC1 && rows[i].d[3])
				h.wr(8'h00, 8'h01);
			h.rd(rows[i].a, v);
			chk("readback", {1'b0, rows[i].r}, {1'b0, v});
			s = rows[i].a == `ASC_ADDR_SC1 ? {3'h0, ctl} : {fmt_reserved, fmt_info};
			chk("decode", rows[i].x & rows[i].m, s & rows[i].m);
		end
		fault_evt <= 4'b1001;
		@(posedge clk);
		fault_evt <= 4'b0000;
		h.rd(`ASC_ADDR_ERR, v);
		chk("error flags", 9'h048, {1'b0, v});
		chk("flag port", 9'h009, {5'h00, err_flags});
		fault_evt <= 4'b0010;
		h.wr(`ASC_ADDR_ERR, 8'h00);
		fault_evt <= 4'b0000;
		h.rd(`ASC_ADDR_ERR, v);
		chk("error race", 9'h010, {1'b0, v});
		h.wr(`ASC_ADDR_ERR, 8'h00);
		h.rd(`ASC_ADDR_ERR, v);
		chk("error clear", 9'h000, {1'b0, v});
		shutdown_group <= 6'h03;
		run_case(8'h00, 1'b0, 6'h21, 6'h2c, 1'b0);
		run_case(8'h20, 1'b0, 6'h21, 6'h2f, 1'b1);
		run_case(8'h20, 1'b1, 6'h16, 6'h10, 1'b1);
		run_case(8'h28, 1'b1, 6'h12, 6'h10, 1'b1);
		run_case(8'h2c, 1'b1, 6'h0b, 6'h3f, 1'b1);
		run_case(8'h22, 1'b0, 6'h16, 6'h10, 1'b1);
		run_case(8'h26, 1'b0, 6'h21, 6'h2f, 1'b1);
		run_case(8'h06, 1'b0, 6'h21, 6'h2c, 1'b0);
		run_case(8'h40, 1'b0, 6'h21, 6'h00, 1'b0);
		// Leave a flag set so that the second reset must clear it
		fault_evt <= 4'b1000;
		@(posedge clk);
		fault_evt <= 4'b0000;
		headphone_select_pin <= 1'b0;
		resetn <= 1'b0;
		reset_chk();
		print_verdict();
	end
endmodule : asc_sysctl_tb
